// File: common/ccaf_pkg.sv
// Shared constants and types for the coil current autofocus controller
package ccaf_pkg;

   // ********************************************
   // Timing
   // ********************************************
   localparam int CLK_MHZ        = 40;
   localparam int SD_TIMEOUT_US  = 750;
   localparam int SD_TIMEOUT_CYC = SD_TIMEOUT_US * CLK_MHZ;
   localparam int PWM_BASE_KHZ   = 500;
   localparam int PWM_BASE_CYC   = (CLK_MHZ * 1000) / PWM_BASE_KHZ;

   // ********************************************
   // Widths and positions
   // ********************************************
   localparam int SP_W       = 10;
   localparam int FSEL_W     = 3;
   localparam int TICK_W     = 16;
   localparam int SDCNT_W    = 16;
   localparam int PCNT_W     = 7;
   localparam int ROM_AW     = 4;
   localparam int ROM_DW     = 8;
   localparam int ROM_LAST   = 15;
   localparam int FRAC_SHIFT = 8;
   // Host side only: least code for open and short checks
   localparam int DETCODE_MIN = 256;

   // ********************************************
   // Values after reset
   // ********************************************
   localparam logic [SP_W-1:0]   SETPT_RST = 10'h000;
   localparam logic [FSEL_W-1:0] FSEL_RST  = 3'h0;
   localparam logic              PWM_RST   = 1'h0;
   localparam logic              TWOP_RST  = 1'h1;

   // ********************************************
   // Types
   // ********************************************
   typedef enum logic [1:0] {
      CCAF_SHUTDOWN = 2'b00,
      CCAF_STANDBY  = 2'b01,
      CCAF_ACTIVE   = 2'b10
   } ccaf_mode_state_t;

   typedef struct packed {
      logic              soft_reset_bit;
      logic [FSEL_W-1:0] freq_sel;
   } ccaf_ctrl_t;

   typedef struct packed {
      logic pwm_mode;
      logic two_period;
   } ccaf_mode_t;

   typedef struct packed {
      logic overtemp_fault_flag;
      logic coil_short_flag;
      logic coil_open_flag;
   } ccaf_fault_t;

endpackage

// File: hdl/ccaf_ctrl.sv
// Coil current autofocus controller: power modes, ramp and drive stage
//
// Operation
// RQ1: Continuous SCL low past a timeout between 0.5 ms and 1 ms puts the block in shutdown.
// RQ2: An SCL rise in shutdown reaches standby well inside 100 us with all registers at default.
// RQ3: Writing a non-zero coil current setpoint switches to active and enables the output stage.
// RQ4: Every setpoint change moves the coil current along a stored smooth ramp, not a step; on leaving active the converter code drops to 0 at once.
// RQ5: In linear style the high-side device acts as a current source following the setpoint.
// RQ6: In PWM style each period drives the high side first, then freewheels through the low side.
// RQ7: The PWM switching frequency is chosen by a control field from 0.5 MHz to 4 MHz.
// RQ8: A single drive-style bit in the mode register picks linear or PWM drive.
// RQ9: The host should use a setpoint of at least 256 when testing for coil open or short.
// RQ10: The I2C link runs at up to 400 kbit/s and the host clocks it no faster; the host model drives SCL faster, in 200 ns periods (5 MHz).
// RQ11: The ramp spans two resonance periods (30 % tolerance) or one (10 % tolerance).
// RQ12: A zero setpoint returns the block to standby.
// RQ13: Setting the soft reset bit while active returns to standby with all registers at default.
// RQ14: An overtemperature, coil short or coil open fault in active forces standby, clears setpoint.
// RQ15: In PWM style the sensed current is regulated against the 10-bit converter code.
// RQ16: The shutdown timer counts only continuous SCL low and restarts on every high level.
`timescale 1ns/1ps
module ccaf_ctrl #(
   parameter int SD_TIMEOUT_CYC_P = ccaf_pkg::SD_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   input  wire logic                            ce_i,
   // Serial clock pin
   input  wire logic                            scl_i,
   // Register writes from the I2C slave
   input  wire logic                            sp_wr_i,
   input  wire logic [ccaf_pkg::SP_W-1:0]       sp_data_i,
   input  wire logic                            ctrl_wr_i,
   input  wire ccaf_pkg::ccaf_ctrl_t            ctrl_data_i,
   input  wire logic                            mode_wr_i,
   input  wire ccaf_pkg::ccaf_mode_t            mode_data_i,
   input  wire logic [ccaf_pkg::TICK_W-1:0]     ramp_tick_i,
   // Analog comparators
   input  wire ccaf_pkg::ccaf_fault_t           fault_i,
   input  wire logic                            cur_reached_i,
   // Register and state view
   output ccaf_pkg::ccaf_mode_state_t           state_o,
   output logic      [ccaf_pkg::SP_W-1:0]       setpoint_o,
   output ccaf_pkg::ccaf_ctrl_t                 ctrl_o,
   output ccaf_pkg::ccaf_mode_t                 mode_o,
   output ccaf_pkg::ccaf_fault_t                status_o,
   output logic                                 ramping_o,
   // Output stage
   output logic      [ccaf_pkg::SP_W-1:0]       dac_code_o,
   output logic                                 stage_en_o,
   output logic                                 lin_en_o,
   output logic                                 hs_on_o,
   output logic                                 ls_on_o
);
   import ccaf_pkg::*;

   // ********************************************
   // Functions
   // ********************************************
   function automatic logic [PCNT_W-1:0] pwm_period(input logic [FSEL_W-1:0] sel);
      int per;
      per = PWM_BASE_CYC / (int'(sel) + 1);
      return PCNT_W'(per);
   endfunction

   function automatic logic [SP_W-1:0] ramp_point(input logic [SP_W-1:0]   a,
                                                  input logic [SP_W-1:0]   b,
                                                  input logic [ROM_DW-1:0] f);
      logic signed [SP_W+ROM_DW+1:0] diff;
      logic signed [SP_W+ROM_DW+1:0] sum;
      diff = $signed({{(ROM_DW+2){1'b0}}, b}) - $signed({{(ROM_DW+2){1'b0}}, a});
      sum  = $signed({{(ROM_DW+2){1'b0}}, a})
           + ((diff * $signed({{(SP_W+2){1'b0}}, f})) >>> FRAC_SHIFT);
      return sum[SP_W-1:0];
   endfunction

   // ********************************************
   // Pin synchronisers
   // ********************************************
   localparam int SYN_W = 5;
   logic [SYN_W-1:0] sync1_ff;
   logic [SYN_W-1:0] sync2_ff;
   logic             scl_q_ff;
   logic             scl_s;
   logic             cmp_s;
   ccaf_fault_t      flt_s;

   assign scl_s = sync2_ff[4];  // see RQ10
   assign cmp_s = sync2_ff[3];
   assign flt_s = sync2_ff[2:0];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         scl_q_ff <= 1'b0;
      end else if (ce_i) begin
         sync1_ff <= {scl_i, cur_reached_i, fault_i};
         sync2_ff <= sync1_ff;
         scl_q_ff <= sync2_ff[4];
      end
   end

   // ********************************************
   // Power modes and registers
   // ********************************************
   ccaf_mode_state_t  state_ff;
   ccaf_mode_state_t  nxt_state;
   logic [SDCNT_W-1:0] sdcnt_ff;
   logic [SDCNT_W-1:0] nxt_sdcnt;
   logic [SP_W-1:0]   sp_ff;
   logic [SP_W-1:0]   nxt_sp;
   ccaf_ctrl_t        ctrl_ff;
   ccaf_ctrl_t        nxt_ctrl;
   ccaf_mode_t        mode_ff;
   ccaf_mode_t        nxt_mode;
   ccaf_fault_t       stat_ff;
   ccaf_fault_t       nxt_stat;
   logic              sd_hit;
   logic              any_flt;
   logic              defaults;

   assign sd_hit  = (sdcnt_ff >= SDCNT_W'(SD_TIMEOUT_CYC_P - 1)) && !scl_s;
   assign any_flt = |flt_s;

   always_comb begin
      nxt_state = state_ff;
      nxt_sp    = sp_ff;
      nxt_ctrl  = ctrl_ff;
      nxt_mode  = mode_ff;
      nxt_stat  = stat_ff;
      defaults  = 1'b0;
      // Restart on every high level so normal SCL low phases never count up far
      if (scl_s) begin
         nxt_sdcnt = '0;  // see RQ16
      end else if (sdcnt_ff != '1) begin
         nxt_sdcnt = sdcnt_ff + 1'b1;  // see RQ16
      end else begin
         nxt_sdcnt = sdcnt_ff;
      end
      if (sp_wr_i) begin
         nxt_sp = sp_data_i;
      end
      if (mode_wr_i) begin
         nxt_mode = mode_data_i;  // see RQ8
      end
      if (ctrl_wr_i) begin
         nxt_ctrl = ctrl_data_i;  // see RQ7
         nxt_ctrl.soft_reset_bit = 1'b0;
      end
      case (state_ff)
         CCAF_SHUTDOWN: begin
            defaults = 1'b1;
            if (scl_s && !scl_q_ff) begin
               nxt_state = CCAF_STANDBY;  // see RQ2
            end
         end
         CCAF_STANDBY: begin
            if (nxt_sp != '0) begin
               nxt_state = CCAF_ACTIVE;  // see RQ3
               nxt_stat  = '0;
            end
         end
         CCAF_ACTIVE: begin
            if (ctrl_wr_i && ctrl_data_i.soft_reset_bit) begin
               nxt_state = CCAF_STANDBY;  // see RQ13
               defaults  = 1'b1;  // see RQ13
            end else if (any_flt) begin
               nxt_state = CCAF_STANDBY;  // see RQ14
               nxt_stat  = stat_ff | flt_s;  // see RQ14
               nxt_sp    = SETPT_RST;  // see RQ14
            end else if (nxt_sp == '0) begin
               nxt_state = CCAF_STANDBY;  // see RQ12
            end
         end
         default: begin
            nxt_state = CCAF_SHUTDOWN;
            defaults  = 1'b1;
         end
      endcase
      // Timeout overrides every other transition
      if (sd_hit) begin
         nxt_state = CCAF_SHUTDOWN;  // see RQ1
         defaults  = 1'b1;
      end
      if (defaults) begin
         nxt_sp   = SETPT_RST;  // see RQ2
         nxt_ctrl = '{soft_reset_bit: 1'b0, freq_sel: FSEL_RST};
         nxt_mode = '{pwm_mode: PWM_RST, two_period: TWOP_RST};
         nxt_stat = '0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= CCAF_SHUTDOWN;
         sdcnt_ff <= '0;
         sp_ff    <= SETPT_RST;
         ctrl_ff  <= '{soft_reset_bit: 1'b0, freq_sel: FSEL_RST};
         mode_ff  <= '{pwm_mode: PWM_RST, two_period: TWOP_RST};
         stat_ff  <= '0;
      end else if (ce_i) begin
         state_ff <= nxt_state;
         sdcnt_ff <= nxt_sdcnt;
         sp_ff    <= nxt_sp;
         ctrl_ff  <= nxt_ctrl;
         mode_ff  <= nxt_mode;
         stat_ff  <= nxt_stat;
      end
   end

   // ********************************************
   // Ringing compensation ramp
   // ********************************************
   logic [SP_W-1:0]   start_ff;
   logic [SP_W-1:0]   nxt_start;
   logic [SP_W-1:0]   tgt_ff;
   logic [SP_W-1:0]   nxt_tgt;
   logic [SP_W-1:0]   dac_ff;
   logic [SP_W-1:0]   nxt_dac;
   logic [ROM_AW-1:0] idx_ff;
   logic [ROM_AW-1:0] nxt_idx;
   logic [TICK_W-1:0] tick_ff;
   logic [TICK_W-1:0] nxt_tick;
   logic              half_ff;
   logic              nxt_half;
   logic              ramp_ff;
   logic              nxt_ramp;
   logic [ROM_DW-1:0] frac;
   logic              act;

   assign act = (state_ff == CCAF_ACTIVE);

   ccaf_ramp_rom u_rom (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .addr_i (idx_ff),
      .data_o (frac)
   );

   always_comb begin
      nxt_start = start_ff;
      nxt_tgt   = tgt_ff;
      nxt_dac   = dac_ff;
      nxt_idx   = idx_ff;
      nxt_tick  = tick_ff;
      nxt_half  = half_ff;
      nxt_ramp  = ramp_ff;
      if (!act) begin
         nxt_start = '0;
         nxt_tgt   = '0;
         nxt_dac   = '0;
         nxt_ramp  = 1'b0;
      end else if (sp_ff != tgt_ff) begin
         // Restart from where the coil is now, even mid-ramp
         nxt_start = dac_ff;  // see RQ4
         nxt_tgt   = sp_ff;
         nxt_idx   = '0;
         nxt_tick  = '0;
         nxt_half  = 1'b0;
         nxt_ramp  = 1'b1;
      end else if (ramp_ff) begin
         nxt_dac = ramp_point(start_ff, tgt_ff, frac);  // see RQ4
         if (tick_ff + 1'b1 >= ramp_tick_i) begin
            nxt_tick = '0;
            // Two-period mode holds every point twice
            nxt_half = mode_ff.two_period && !half_ff;  // see RQ11
            if (!nxt_half) begin
               if (idx_ff == ROM_AW'(ROM_LAST)) begin
                  nxt_ramp = 1'b0;
                  nxt_dac  = tgt_ff;
               end else begin
                  nxt_idx = idx_ff + 1'b1;
               end
            end
         end else begin
            nxt_tick = tick_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_ff <= '0;
         tgt_ff   <= '0;
         dac_ff   <= '0;
         idx_ff   <= '0;
         tick_ff  <= '0;
         half_ff  <= 1'b0;
         ramp_ff  <= 1'b0;
      end else if (ce_i) begin
         start_ff <= nxt_start;
         tgt_ff   <= nxt_tgt;
         dac_ff   <= nxt_dac;
         idx_ff   <= nxt_idx;
         tick_ff  <= nxt_tick;
         half_ff  <= nxt_half;
         ramp_ff  <= nxt_ramp;
      end
   end

   // ********************************************
   // PWM half bridge
   // ********************************************
   logic [PCNT_W-1:0] pcnt_ff;
   logic [PCNT_W-1:0] nxt_pcnt;
   logic              hs_ff;
   logic              nxt_hs;
   logic              pwm_act;

   assign pwm_act = act && mode_ff.pwm_mode;

   always_comb begin
      nxt_pcnt = '0;
      nxt_hs   = 1'b0;
      if (pwm_act) begin
         if (pcnt_ff + 1'b1 >= pwm_period(ctrl_ff.freq_sel)) begin
            nxt_pcnt = '0;  // see RQ7
            nxt_hs   = 1'b1;  // see RQ6
         end else begin
            nxt_pcnt = pcnt_ff + 1'b1;
            // Comparator sees sense current against the converter code
            nxt_hs   = hs_ff && !cmp_s;  // see RQ15
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pcnt_ff <= '0;
         hs_ff   <= 1'b0;
      end else if (ce_i) begin
         pcnt_ff <= nxt_pcnt;
         hs_ff   <= nxt_hs;
      end
   end

   // ********************************************
   // Outputs
   // ********************************************
   assign state_o    = state_ff;
   assign setpoint_o = sp_ff;
   assign ctrl_o     = ctrl_ff;
   assign mode_o     = mode_ff;
   assign status_o   = stat_ff;
   assign ramping_o  = ramp_ff;
   assign dac_code_o = dac_ff;  // see RQ5
   assign stage_en_o = act;  // see RQ3
   assign lin_en_o   = act && !mode_ff.pwm_mode;  // see RQ5
   assign hs_on_o    = pwm_act && hs_ff;  // see RQ6
   assign ls_on_o    = pwm_act && !hs_ff;  // see RQ6

endmodule

// File: hdl/ccaf_ramp_rom.sv
// Ramp profile table with registered read data
`timescale 1ns/1ps
module ccaf_ramp_rom (
   // Clock
   input  wire logic                         clk_i,
   input  wire logic                         ce_i,
   // Read port
   input  wire logic [ccaf_pkg::ROM_AW-1:0]  addr_i,
   output logic      [ccaf_pkg::ROM_DW-1:0]  data_o
);
   import ccaf_pkg::*;

   logic [ROM_DW-1:0] nxt_data;

   // Smooth S-curve, fraction of the step out of 256
   always_comb begin
      case (addr_i)
         4'h0:    nxt_data = 8'h02;
         4'h1:    nxt_data = 8'h08;
         4'h2:    nxt_data = 8'h12;
         4'h3:    nxt_data = 8'h21;
         4'h4:    nxt_data = 8'h34;
         4'h5:    nxt_data = 8'h4A;
         4'h6:    nxt_data = 8'h62;
         4'h7:    nxt_data = 8'h7B;
         4'h8:    nxt_data = 8'h94;
         4'h9:    nxt_data = 8'hAC;
         4'hA:    nxt_data = 8'hC2;
         4'hB:    nxt_data = 8'hD6;
         4'hC:    nxt_data = 8'hE6;
         4'hD:    nxt_data = 8'hF2;
         4'hE:    nxt_data = 8'hFA;
         default: nxt_data = 8'hFF;
      endcase
   end

   // No reset: the table output is pure data
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         data_o <= nxt_data;
      end
   end

endmodule

// File: verif/ccaf_ctrl_checker.sv
// Port assertions for the autofocus controller
`timescale 1ns/1ps
module ccaf_ctrl_checker #(
   parameter int SD_TIMEOUT_CYC_P = 50
) (
   // Clock and reset
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   // Inputs
   input wire logic                       ce_i,
   input wire logic                       scl_i,
   input wire logic                       sp_wr_i,
   input wire logic [ccaf_pkg::SP_W-1:0]  sp_data_i,
   input wire logic                       ctrl_wr_i,
   input wire ccaf_pkg::ccaf_ctrl_t       ctrl_data_i,
   input wire ccaf_pkg::ccaf_fault_t      fault_i,
   // Outputs
   input wire ccaf_pkg::ccaf_mode_state_t state_o,
   input wire logic [ccaf_pkg::SP_W-1:0]  setpoint_o,
   input wire ccaf_pkg::ccaf_mode_t       mode_o,
   input wire ccaf_pkg::ccaf_fault_t      status_o,
   input wire logic                       ramping_o,
   input wire logic                       stage_en_o,
   input wire logic                       lin_en_o,
   input wire logic                       hs_on_o,
   input wire logic                       ls_on_o
);
   import ccaf_pkg::*;
   // ****************************************
   // Raw serial clock low time
   // ****************************************
   logic [15:0] low_cnt_ff;
   logic [15:0] nxt_low_cnt;
   always_comb begin
      nxt_low_cnt = low_cnt_ff;
      if (scl_i)
         nxt_low_cnt = 16'h0000;
      else if (low_cnt_ff != 16'hFFFF)
         nxt_low_cnt = low_cnt_ff + 16'h0001;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         low_cnt_ff <= 16'h0000;
      else
         low_cnt_ff <= nxt_low_cnt;
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence seq_new_code;
      ce_i && sp_wr_i && sp_data_i != 10'h000 && state_o != CCAF_SHUTDOWN;
   endsequence
   sequence seq_fault_held;
      (ce_i && state_o == CCAF_ACTIVE && fault_i != 3'h0) ##1 (fault_i != 3'h0)[*3];
   endsequence
   chk_active_entry: assert property (seq_new_code |=>
      state_o == CCAF_ACTIVE && setpoint_o == $past(sp_data_i)) else $error("no active entry");
   chk_ramp_start: assert property (seq_new_code and (!ramping_o && sp_data_i != setpoint_o)
      |-> ##[1:2] ramping_o) else $error("ramp not started");
   chk_zero_standby: assert property (ce_i && sp_wr_i && sp_data_i == 10'h000
      && state_o == CCAF_ACTIVE |=> state_o == CCAF_STANDBY) else $error("zero kept active");
   chk_stage_active: assert property (stage_en_o == (state_o == CCAF_ACTIVE))
      else $error("stage enable wrong");
   chk_linear_sel: assert property (lin_en_o == (stage_en_o && !mode_o.pwm_mode))
      else $error("linear enable wrong");
   chk_half_bridge: assert property ((stage_en_o && mode_o.pwm_mode) ?
      (hs_on_o != ls_on_o) : !(hs_on_o || ls_on_o)) else $error("bridge gates wrong");
   chk_soft_reset: assert property (ce_i && ctrl_wr_i && ctrl_data_i.soft_reset_bit
      && state_o == CCAF_ACTIVE |=> state_o == CCAF_STANDBY && setpoint_o == 10'h000)
      else $error("soft reset ignored");
   chk_fault_standby: assert property (seq_fault_held |-> ##[0:1]
      (state_o == CCAF_STANDBY && setpoint_o == 10'h000 && status_o != 3'h0))
      else $error("fault not handled");
   chk_sd_enter: assert property (low_cnt_ff == SD_TIMEOUT_CYC_P + 6
      |-> state_o == CCAF_SHUTDOWN) else $error("no shutdown");
   chk_sd_quiet: assert property (state_o != CCAF_SHUTDOWN && low_cnt_ff < SD_TIMEOUT_CYC_P - 4
      |=> state_o != CCAF_SHUTDOWN) else $error("early shutdown");
   chk_wake_up: assert property (state_o == CCAF_SHUTDOWN && $rose(scl_i) |-> ##[1:8]
      (state_o == CCAF_STANDBY && setpoint_o == 10'h000 && mode_o.two_period))
      else $error("no wake up");
endmodule
bind ccaf_ctrl ccaf_ctrl_checker #(.SD_TIMEOUT_CYC_P(SD_TIMEOUT_CYC_P)) u_ccaf_chk (
   .clk_i, .rst_i, .ce_i, .scl_i, .sp_wr_i, .sp_data_i, .ctrl_wr_i, .ctrl_data_i, .fault_i,
   .state_o, .setpoint_o, .mode_o, .status_o, .ramping_o, .stage_en_o, .lin_en_o,
   .hs_on_o, .ls_on_o);

// File: verif/ccaf_host_model.sv
// Host side model: serial clock frames and register writes
`timescale 1ns/1ps
module ccaf_host_model (
   // Clock
   input  wire logic                  clk_i,
   // Serial clock and writes
   output logic                       scl_o,
   output logic                       sp_wr_o,
   output logic [ccaf_pkg::SP_W-1:0]  sp_data_o,
   output logic                       ctrl_wr_o,
   output ccaf_pkg::ccaf_ctrl_t       ctrl_data_o,
   output logic                       mode_wr_o,
   output ccaf_pkg::ccaf_mode_t       mode_data_o
);
   import ccaf_pkg::*;
   initial begin
      scl_o = 1'b0;
      {sp_wr_o, ctrl_wr_o, mode_wr_o} = 3'h0;
      {sp_data_o, ctrl_data_o, mode_data_o} = 16'h0000;
   end
   // ****************************************
   // Write: sel bit 0 setpoint, 1 control, 2 mode
   // ****************************************
   task automatic wr(input logic [2:0] sel, input logic [SP_W-1:0] d);
      @(posedge clk_i);
      {mode_wr_o, ctrl_wr_o, sp_wr_o} <= sel;
      sp_data_o <= d;
      ctrl_data_o <= d[3:0];
      mode_data_o <= d[1:0];
      @(posedge clk_i);
      {mode_wr_o, ctrl_wr_o, sp_wr_o} <= 3'h0;
      // Released data no longer shows the written value
      sp_data_o <= ~d;
      ctrl_data_o <= ~d[3:0];
      mode_data_o <= ~d[1:0];
   endtask
   // ****************************************
   // Serial clock: 200 ns periods, idles high
   // ****************************************
   task automatic scl_frame(input int n);
      repeat (n) begin
         @(posedge clk_i);
         scl_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         scl_o <= 1'b1;
         repeat (3) @(posedge clk_i);
      end
   endtask
   task automatic scl_set(input logic v);
      @(posedge clk_i);
      scl_o <= v;
   endtask
endmodule

// File: verif/coil_current_autofocus_ctrl_tb_top.sv
// Self-checking bench for the autofocus controller
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module coil_current_autofocus_ctrl_tb_top;
   import ccaf_pkg::*;
   localparam int SD = 50;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cur_reached_i = 1'b0, scl;
   logic [TICK_W-1:0] ramp_tick_i = 16'h0002;
   ccaf_fault_t fault_i = 3'h0;
   logic sp_wr, ctrl_wr, mode_wr, ramping_o, stage_en_o, lin_en_o, hs_on_o, ls_on_o;
   logic [SP_W-1:0] sp_data, setpoint_o, dac_code_o, d;
   ccaf_ctrl_t ctrl_data, ctrl_o;
   ccaf_mode_t mode_data, mode_o;
   ccaf_fault_t status_o;
   ccaf_mode_state_t state_o;
   int fails = 0, tests_run = 0, cyc = 0, p, n;
   time t0;
   always #12.5 clk_i = ~clk_i;
   // Comparator trips one cycle after the high side opens
   always @(posedge clk_i) cur_reached_i <= hs_on_o;
   ccaf_host_model u_host (.clk_i(clk_i), .scl_o(scl), .sp_wr_o(sp_wr), .sp_data_o(sp_data),
      .ctrl_wr_o(ctrl_wr), .ctrl_data_o(ctrl_data), .mode_wr_o(mode_wr), .mode_data_o(mode_data));
   ccaf_ctrl #(.SD_TIMEOUT_CYC_P(SD)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .scl_i(scl), .sp_wr_i(sp_wr), .sp_data_i(sp_data), .ctrl_wr_i(ctrl_wr),
      .ctrl_data_i(ctrl_data), .mode_wr_i(mode_wr), .mode_data_i(mode_data),
      .ramp_tick_i(ramp_tick_i), .fault_i(fault_i), .cur_reached_i(cur_reached_i),
      .state_o(state_o), .setpoint_o(setpoint_o), .ctrl_o(ctrl_o), .mode_o(mode_o),
      .status_o(status_o), .ramping_o(ramping_o), .dac_code_o(dac_code_o),
      .stage_en_o(stage_en_o), .lin_en_o(lin_en_o), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o));
   // ****************************************
   // Expectations and helpers
   // ****************************************
   function automatic int exp_period(input int f);
      return PWM_BASE_CYC / (f + 1);
   endfunction
   function automatic logic exp_lin(input logic pwm);
      return !pwm;
   endfunction
   // Counts ramp cycles, sampling away from the launching edge
   task automatic wait_ramp(output int cnt);
      cnt = 0;
      repeat (2) @(negedge clk_i);
      while (ramping_o !== 1'b0) begin
         cnt++;
         @(negedge clk_i);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Ceiling well above the expected few thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         test_done;
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(56));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      u_host.scl_set(1'b1);
      repeat (10) @(negedge clk_i);
      `CHK(state_o, CCAF_STANDBY)
      `CHK(mode_o, {PWM_RST, TWOP_RST})
      `CHK(ctrl_o.freq_sel, FSEL_RST)
      u_host.scl_frame(10);
      `CHK(state_o, CCAF_STANDBY)
      for (int i = 0; i < 16; i++) begin
         // Always a new non-zero code, so every write starts a ramp
         d = (i == 0) ? 10'h3FF : 10'((d + $urandom_range(0, 1021)) % 1023 + 1);
         p = $urandom;
         u_host.wr(3'b100, {8'h00, 2'(p)});
         u_host.wr(3'b001, d);
         wait_ramp(n);
         `CHK(n, (ROM_LAST + 1) * int'(ramp_tick_i) * (1 + int'(p[0])))
         `CHK(setpoint_o, d)
         `CHK(stage_en_o, 1'b1)
         `CHK(dac_code_o, d)
         `CHK(lin_en_o, exp_lin(p[1]))
      end
      u_host.wr(3'b001, 10'h000);
      repeat (2) @(negedge clk_i);
      `CHK(state_o, CCAF_STANDBY)
      // Frozen clock enable must swallow a write
      @(posedge clk_i);
      ce_i <= 1'b0;
      u_host.wr(3'b001, 10'h0AA);
      repeat (2) @(negedge clk_i);
      `CHK(state_o, CCAF_STANDBY)
      `CHK(setpoint_o, 10'h000)
      @(posedge clk_i);
      ce_i <= 1'b1;
      u_host.wr(3'b100, 10'h002);
      u_host.wr(3'b001, 10'h155);
      for (int f = 0; f < 8; f++) begin
         u_host.wr(3'b010, 10'(f));
         repeat (2) @(posedge hs_on_o);
         t0 = $time;
         #1;
         `CHK(ls_on_o, 1'b0)
         @(posedge hs_on_o);
         p = int'(($time - t0) / 25);
         `CHK(p, exp_period(f))
      end
      u_host.wr(3'b010, 10'h00D);
      repeat (2) @(negedge clk_i);
      `CHK(state_o, CCAF_STANDBY)
      `CHK(setpoint_o, SETPT_RST)
      `CHK(stage_en_o, 1'b0)
      `CHK(mode_o, {PWM_RST, TWOP_RST})
      `CHK(ctrl_o.freq_sel, FSEL_RST)
      for (int k = 0; k < 3; k++) begin
         u_host.wr(3'b001, 10'(DETCODE_MIN + k));
         repeat (3) @(negedge clk_i);
         `CHK(status_o, 3'h0)
         @(posedge clk_i);
         fault_i <= 3'(1 << k);
         repeat (6) @(negedge clk_i);
         `CHK(state_o, CCAF_STANDBY)
         `CHK(setpoint_o, 10'h000)
         `CHK(status_o, 3'(1 << k))
         @(posedge clk_i);
         fault_i <= 3'h0;
      end
      u_host.scl_set(1'b0);
      repeat (SD + 10) @(negedge clk_i);
      `CHK(state_o, CCAF_SHUTDOWN)
      u_host.wr(3'b001, 10'h100);
      @(negedge clk_i);
      `CHK(setpoint_o, 10'h000)
      u_host.scl_set(1'b1);
      repeat (10) @(negedge clk_i);
      `CHK(state_o, CCAF_STANDBY)
      test_done;
   end
endmodule
